// *** mdc_pkg.sv ***
// constants and types shared by the multichannel transfer controller
// assumes a single processor clock domain and synchronous reset
package mdc_pkg;
  // ****************************************
  // channel map and widths
  // ****************************************
  localparam int CH_NUM = 10;
  localparam int CH_W = 4;
  localparam int SHARE_BASE = 4; // channels 4..7 shared with link use
  localparam int SHARE_NUM = 4;
  localparam int EXTREQ_BASE = 8; // channels 8..9 paced by pin requests
  localparam int EXTREQ_NUM = 2;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 16;
  localparam int WORD_W = 48;
  localparam int EBUS_W = 16;
  localparam int SYNC_LEN = 3;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] PACK_16 = 2'h0; // one bus beat per word
  localparam logic [1:0] PACK_32 = 2'h1;
  localparam logic [1:0] PACK_48 = 2'h2;
  localparam logic [1:0] PATH_EXT = 2'h0; // internal <-> external bus
  localparam logic [1:0] PATH_IO = 2'h1; // internal <-> serial/link port
  localparam logic [1:0] PATH_E2E = 2'h2; // external memory <-> external device
  localparam logic [CNT_W-1:0] CNT_LAST = 16'h0001;
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_RWAIT, ST_WR, ST_DONE} mdc_state_e;
endpackage : mdc_pkg

// *** mdc_dma_ctrl.sv ***
// ten-channel transfer controller with its dual-ported internal memory
// assumes external bus ack and serial/link port strobes share clock;
// only the two pin requests are asynchronous
`timescale 1ns/10ps
module mdc_dma_ctrl import mdc_pkg::*; #(
  parameter int MEM_AW = 10
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic core_en,
  input wire logic core_we,
  input wire logic [MEM_AW-1:0] core_addr,
  input wire logic [WORD_W-1:0] core_wdata,
  output logic [WORD_W-1:0] core_rdata,
  input wire logic cfg_we,
  input wire logic [CH_W-1:0] cfg_chan,
  input wire logic [ADDR_W-1:0] cfg_int_addr,
  input wire logic [ADDR_W-1:0] cfg_ext_addr,
  input wire logic [CNT_W-1:0] cfg_count,
  input wire logic [1:0] cfg_path,
  input wire logic cfg_to_int,
  input wire logic [1:0] cfg_pack,
  input wire logic [CH_NUM-1:0] chan_req,
  input wire logic [SHARE_NUM-1:0] link_req,
  input wire logic [SHARE_NUM-1:0] share_link,
  input wire logic [EXTREQ_NUM-1:0] ext_xfer_request,
  output logic [EXTREQ_NUM-1:0] ext_xfer_grant,
  output logic ext_req,
  output logic ext_we,
  output logic [ADDR_W-1:0] ext_addr,
  output logic [EBUS_W-1:0] ext_wdata,
  input wire logic [EBUS_W-1:0] ext_rdata,
  input wire logic ext_ack,
  output logic io_strobe,
  output logic [CH_W-1:0] io_chan,
  output logic [WORD_W-1:0] io_wdata,
  input wire logic [WORD_W-1:0] io_rdata,
  output logic [CH_NUM-1:0] chan_active,
  output logic [CH_NUM-1:0] chan_pending,
  output logic [SHARE_NUM-1:0] link_owner,
  output logic [CH_NUM-1:0] done_irq
);
  // ****************************************
  // storage
  // ****************************************
  logic [WORD_W-1:0] mem [2**MEM_AW];
  logic [WORD_W-1:0] core_rdata_q, dma_rdata_q, word_q, io_wdata_q;
  logic [ADDR_W-1:0] ia_q [CH_NUM], ea_q [CH_NUM], pia_q [CH_NUM], pea_q [CH_NUM];
  logic [CNT_W-1:0] cnt_q [CH_NUM], pcnt_q [CH_NUM];
  logic [1:0] path_q [CH_NUM], pack_q [CH_NUM], ppath_q [CH_NUM], ppack_q [CH_NUM];
  logic [CH_NUM-1:0] toint_q, ptoint_q, active_q, pend_q, done_q;
  logic [SHARE_NUM-1:0] owner_q;
  logic [EXTREQ_NUM-1:0] sync1_q, sync2_q, sync3_q, ext_lvl_q, grant_q;
  mdc_state_e st_q;
  logic [CH_W-1:0] cur_q;
  logic [ADDR_W-1:0] cia_q, cea_q, ext_addr_q;
  logic [1:0] beat_q;
  logic ext_req_q, ext_we_q, io_strobe_q;
  logic [EBUS_W-1:0] ext_wdata_q;

  // ****************************************
  // request selection
  // ****************************************
  logic [CH_NUM-1:0] req_src, elig, win_oh;
  logic [CH_W-1:0] win_idx;
  logic any_elig, cur_int, cur_src_ext, cur_dst_ext, last_beat, cur_done;
  logic dma_en, dma_we;
  logic [MEM_AW-1:0] dma_addr;
  logic [CNT_W-1:0] cur_cnt;
  logic [1:0] cur_path, cur_pack;
  logic cur_toint;
  logic [ADDR_W-1:0] cia_nxt;
  logic [EBUS_W-1:0] beat_nxt;
  logic cfg_free;
  assign cur_cnt = cnt_q[cur_q];
  assign cur_path = path_q[cur_q];
  assign cur_pack = pack_q[cur_q];
  assign cur_toint = toint_q[cur_q];
  // shared channels take their request from the link side when it owns them
  always_comb begin
    req_src = chan_req;
    for (int k = 0; k < SHARE_NUM; k++) begin
      if (owner_q[k]) begin
        req_src[SHARE_BASE+k] = link_req[k];
      end
    end
    for (int k = 0; k < EXTREQ_NUM; k++) begin
      req_src[EXTREQ_BASE+k] = chan_req[EXTREQ_BASE+k] | ext_lvl_q[k];
    end
  end
  assign elig = req_src & active_q;
  assign any_elig = |elig;
  assign win_oh = elig & (~elig + 1'b1);
  always_comb begin
    win_idx = '0;
    for (int i = 0; i < CH_NUM; i++) begin
      if (win_oh[i]) begin
        win_idx = CH_W'(i);
      end
    end
  end
  // path decode: external source/destination and internal memory use
  assign cur_int = (cur_path != PATH_E2E);
  assign cur_src_ext = (cur_path == PATH_E2E) || (cur_path == PATH_EXT && cur_toint);
  assign cur_dst_ext = (cur_path == PATH_E2E) || (cur_path == PATH_EXT && !cur_toint);
  // illegal pack code 3 runs as a 48-bit word rather than overrunning the word
  assign last_beat = (beat_q == cur_pack) || (beat_q == 2'h2);
  assign cur_done = (cur_cnt == CNT_LAST);
  // internal address written back; e2e has already stepped it per beat
  assign cia_nxt = cur_int ? cia_q + 1'b1 : cia_q;
  // data of the beat after the current one; never indexes past the word
  assign beat_nxt = (beat_q == 2'h0) ? word_q[2*EBUS_W-1:EBUS_W] :
                    word_q[3*EBUS_W-1:2*EBUS_W];
  // a completing channel with nothing queued may be reloaded in its done cycle
  assign cfg_free = !active_q[cfg_chan] ||
                    (st_q == ST_DONE && cur_done && cur_q == cfg_chan && !pend_q[cur_q]);
  // transfer side of the memory; one access per word, never waits on core
  assign dma_en = (st_q == ST_RD && cur_int && !cur_toint) ||
                  (st_q == ST_WR && cur_int && cur_toint);
  assign dma_we = (st_q == ST_WR);
  assign dma_addr = cia_q[MEM_AW-1:0];

  // ****************************************
  // dual-ported internal memory
  // ****************************************
  // one process so both ports own the array; transfer write wins a collision
  always_ff @(posedge clock) begin
    if (ce) begin
      if (core_en && core_we) begin
        mem[core_addr] <= core_wdata;
      end
      if (dma_en && dma_we) begin
        mem[dma_addr] <= word_q;
      end
    end
  end
  // registered read data for both ports
  always_ff @(posedge clock) begin
    if (srst) begin
      core_rdata_q <= '0;
      dma_rdata_q <= '0;
    end else if (ce) begin
      if (core_en) begin
        core_rdata_q <= mem[core_addr];
      end
      if (dma_en) begin
        dma_rdata_q <= mem[dma_addr];
      end
    end
  end

  // ****************************************
  // pin request synchronisers
  // ****************************************
  // three stages; level moves only when stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      ext_lvl_q <= '0;
    end else if (ce) begin
      sync1_q <= ext_xfer_request;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      ext_lvl_q <= (ext_lvl_q & (sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));
    end
  end

  // ****************************************
  // channel descriptors
  // ****************************************
  // a write to an idle channel starts it, to a busy one queues the next link
  always_ff @(posedge clock) begin
    if (srst) begin
      active_q <= '0;
      pend_q <= '0;
      owner_q <= '0;
    end else if (ce) begin
      for (int k = 0; k < SHARE_NUM; k++) begin
        if (!active_q[SHARE_BASE+k]) begin
          owner_q[k] <= share_link[k];
        end
      end
      if (st_q == ST_DONE) begin
        ia_q[cur_q] <= cia_nxt;
        ea_q[cur_q] <= cea_q;
        cnt_q[cur_q] <= cur_cnt - 1'b1;
        if (cur_done) begin
          active_q[cur_q] <= pend_q[cur_q];
          pend_q[cur_q] <= 1'b0;
          ia_q[cur_q] <= pia_q[cur_q];
          ea_q[cur_q] <= pea_q[cur_q];
          cnt_q[cur_q] <= pcnt_q[cur_q];
          path_q[cur_q] <= ppath_q[cur_q];
          pack_q[cur_q] <= ppack_q[cur_q];
          toint_q[cur_q] <= ptoint_q[cur_q];
        end
      end
      if (cfg_we && cfg_count != '0 && 32'(cfg_chan) < CH_NUM) begin
        if (cfg_free) begin
          active_q[cfg_chan] <= 1'b1;
          ia_q[cfg_chan] <= cfg_int_addr;
          ea_q[cfg_chan] <= cfg_ext_addr;
          cnt_q[cfg_chan] <= cfg_count;
          path_q[cfg_chan] <= cfg_path;
          pack_q[cfg_chan] <= cfg_pack;
          toint_q[cfg_chan] <= cfg_to_int;
        end else begin
          pend_q[cfg_chan] <= 1'b1;
          pia_q[cfg_chan] <= cfg_int_addr;
          pea_q[cfg_chan] <= cfg_ext_addr;
          pcnt_q[cfg_chan] <= cfg_count;
          ppath_q[cfg_chan] <= cfg_path;
          ppack_q[cfg_chan] <= cfg_pack;
          ptoint_q[cfg_chan] <= cfg_to_int;
        end
      end
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  // one word per service: read source, write destination, write back
  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= ST_IDLE;
      cur_q <= '0;
      cia_q <= '0;
      cea_q <= '0;
      beat_q <= '0;
      word_q <= '0;
      ext_req_q <= 1'b0;
      ext_we_q <= 1'b0;
      ext_addr_q <= '0;
      ext_wdata_q <= '0;
      io_strobe_q <= 1'b0;
      io_wdata_q <= '0;
      done_q <= '0;
      grant_q <= '0;
    end else if (ce) begin
      done_q <= '0;
      grant_q <= '0;
      io_strobe_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: if (any_elig) begin
          cur_q <= win_idx;
          cia_q <= ia_q[win_idx];
          cea_q <= ea_q[win_idx];
          beat_q <= '0;
          st_q <= ST_RD;
        end
        ST_RD: if (cur_src_ext) begin
          if (!ext_req_q) begin
            ext_req_q <= 1'b1;
            ext_we_q <= 1'b0;
            ext_addr_q <= cea_q;
          end else if (ext_ack) begin
            word_q[beat_q*EBUS_W +: EBUS_W] <= ext_rdata;
            cea_q <= cea_q + 1'b1;
            ext_addr_q <= cea_q + 1'b1;
            beat_q <= last_beat ? 2'h0 : beat_q + 1'b1;
            ext_req_q <= !last_beat;
            st_q <= last_beat ? ST_WR : ST_RD;
          end
        end else begin
          io_strobe_q <= (cur_path == PATH_IO) && cur_toint;
          st_q <= ST_RWAIT;
        end
        ST_RWAIT: begin
          word_q <= cur_toint ? io_rdata : dma_rdata_q;
          st_q <= ST_WR;
        end
        ST_WR: if (cur_dst_ext) begin
          if (!ext_req_q) begin
            ext_req_q <= 1'b1;
            ext_we_q <= 1'b1;
            ext_addr_q <= (cur_path == PATH_E2E) ? cia_q : cea_q;
            ext_wdata_q <= word_q[beat_q*EBUS_W +: EBUS_W];
          end else if (ext_ack) begin
            if (cur_path == PATH_E2E) begin
              cia_q <= cia_q + 1'b1;
            end else begin
              cea_q <= cea_q + 1'b1;
            end
            ext_addr_q <= ext_addr_q + 1'b1;
            ext_wdata_q <= beat_nxt;
            beat_q <= last_beat ? 2'h0 : beat_q + 1'b1;
            ext_req_q <= !last_beat;
            st_q <= last_beat ? ST_DONE : ST_WR;
          end
        end else begin
          io_strobe_q <= (cur_path == PATH_IO) && !cur_toint;
          io_wdata_q <= word_q;
          st_q <= ST_DONE;
        end
        ST_DONE: begin
          if (cur_int) begin
            cia_q <= cia_q + 1'b1;
          end
          done_q[cur_q] <= cur_done;
          for (int k = 0; k < EXTREQ_NUM; k++) begin
            grant_q[k] <= (32'(cur_q) == EXTREQ_BASE + k);
          end
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign core_rdata = core_rdata_q;
  assign ext_xfer_grant = grant_q;
  assign ext_req = ext_req_q;
  assign ext_we = ext_we_q;
  assign ext_addr = ext_addr_q;
  assign ext_wdata = ext_wdata_q;
  assign io_strobe = io_strobe_q;
  assign io_chan = cur_q;
  assign io_wdata = io_wdata_q;
  assign chan_active = active_q;
  assign chan_pending = pend_q;
  assign link_owner = owner_q;
  assign done_irq = done_q;

  // ****************************************
  // checks
  // ****************************************
  logic [WORD_W-1:0] core_peek;
  assign core_peek = mem[core_addr];
  a_win_lowest: assert property (@(posedge clock) disable iff (srst || !ce)
    st_q == ST_IDLE && any_elig |=> cur_q == $past(win_idx)) else $error("wrong channel won");
  a_core_read: assert property (@(posedge clock) disable iff (srst || !ce)
    core_en && !core_we |=> core_rdata == $past(core_peek)) else $error("core read lost");
  a_dma_read: assert property (@(posedge clock) disable iff (srst || !ce)
    dma_en && !dma_we |=> st_q == ST_RWAIT) else $error("transfer read not single cycle");
  a_done_pulse: assert property (@(posedge clock) disable iff (srst || !ce)
    st_q == ST_DONE && cur_done |=> done_irq[$past(cur_q)] ##1 !done_irq[$past(cur_q, 2)])
    else $error("done pulse wrong");
  a_chain_run: assert property (@(posedge clock) disable iff (srst || !ce)
    st_q == ST_DONE && cur_done && pend_q[cur_q] && !cfg_we |=> chan_active[$past(cur_q)])
    else $error("chained descriptor not loaded");
  a_pack_beats: assert property (@(posedge clock) disable iff (srst || !ce)
    ext_req_q && ext_ack && last_beat |=> !ext_req_q) else $error("beat count wrong");
  a_grant_src: assert property (@(posedge clock) disable iff (srst || !ce)
    |grant_q |-> $past(st_q) == ST_DONE && 32'($past(cur_q)) >= EXTREQ_BASE)
    else $error("grant without service");
  a_share_hold: assert property (@(posedge clock) disable iff (srst || !ce)
    ((owner_q ^ $past(owner_q)) & $past(active_q[SHARE_BASE +: SHARE_NUM])) == '0)
    else $error("owner switched while active");
  a_chan_range: assert property (@(posedge clock) disable iff (srst || !ce)
    st_q != ST_IDLE |-> 32'(cur_q) < CH_NUM && active_q[cur_q])
    else $error("inactive or unknown channel served");
  a_io_path: assert property (@(posedge clock) disable iff (srst || !ce)
    io_strobe_q |-> cur_path == PATH_IO) else $error("port strobe on wrong path");
  c_chain: cover property (@(posedge clock) st_q == ST_DONE && cur_done && pend_q[cur_q]);
  c_grant: cover property (@(posedge clock) grant_q[0] ##[1:40] grant_q[1]);
  c_e2e: cover property (@(posedge clock) st_q == ST_DONE && cur_path == PATH_E2E);
endmodule : mdc_dma_ctrl

// *** mdc_far_model.sv ***
// far-side stand-in: external bus memory and serial/link port data source
// assumes the controller's clock; bus answers after wait_n idle cycles
`timescale 1ns/10ps
module mdc_far_model import mdc_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic [3:0] wait_n,
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [EBUS_W-1:0] ext_wdata,
  output logic [EBUS_W-1:0] ext_rdata,
  output logic ext_ack,
  input wire logic io_strobe,
  input wire logic [CH_W-1:0] io_chan,
  output logic [WORD_W-1:0] io_rdata
);
  // ********************
  // external bus memory
  // ********************
  logic [EBUS_W-1:0] mem [0:255];
  logic [3:0] wait_q;
  logic tog_q;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // one ack pulse per beat; read data flips outside the ack so stale data never matches
  always @(posedge clock) begin
    tog_q <= ~tog_q;
    if (srst) begin
      ext_ack <= 1'b0;
      wait_q <= 4'h0;
      tog_q <= 1'b0;
      ext_rdata <= 16'h0000;
    end else if (ext_ack) begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
    end else if (ext_req && wait_q == wait_n) begin
      ext_ack <= 1'b1;
      wait_q <= 4'h0;
      ext_rdata <= mem[ext_addr[7:0]];
      if (ext_we) begin
        mem[ext_addr[7:0]] <= ext_wdata;
      end
    end else begin
      wait_q <= ext_req ? wait_q + 4'h1 : 4'h0;
      ext_rdata <= ~ext_rdata;
    end
  end
  // port data only valid while strobed, a toggling pattern otherwise
  assign io_rdata = io_strobe ? {12'hC3C, 32'h0000_0000, io_chan} : {24{tog_q, ~tog_q}};
endmodule : mdc_far_model

// *** tb.sv ***
// self-checking bench for the ten-channel transfer controller
// assumes mdc_pkg and mdc_far_model; inputs change on the falling edge
`timescale 1ns/10ps
module tb;
  import mdc_pkg::*;
  localparam int AW = 6;
  localparam int LIMIT = 20000;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic core_en = 1'b0;
  logic core_we = 1'b0;
  logic [AW-1:0] core_addr = '0;
  logic [WORD_W-1:0] core_wdata = '0;
  logic cfg_we = 1'b0;
  logic [CH_W-1:0] cfg_chan = '0;
  logic [ADDR_W-1:0] cfg_int_addr = '0;
  logic [ADDR_W-1:0] cfg_ext_addr = '0;
  logic [CNT_W-1:0] cfg_count = '0;
  logic [1:0] cfg_path = '0;
  logic cfg_to_int = 1'b0;
  logic [1:0] cfg_pack = '0;
  logic [CH_NUM-1:0] chan_req = '0;
  logic [SHARE_NUM-1:0] link_req = '0;
  logic [SHARE_NUM-1:0] share_link = '0;
  logic [EXTREQ_NUM-1:0] ext_xfer_request = '0;
  logic [3:0] wait_n = 4'h0;
  logic [EXTREQ_NUM-1:0] ext_xfer_grant;
  logic ext_req, ext_we, ext_ack, io_strobe;
  logic [ADDR_W-1:0] ext_addr;
  logic [EBUS_W-1:0] ext_wdata, ext_rdata;
  logic [CH_W-1:0] io_chan;
  logic [WORD_W-1:0] core_rdata, io_wdata, io_rdata;
  logic [CH_NUM-1:0] chan_active, chan_pending, done_irq;
  logic [SHARE_NUM-1:0] link_owner;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int done_n [CH_NUM];
  int grants [EXTREQ_NUM];
  logic [CH_W-1:0] chq [$];
  logic [WORD_W-1:0] wq [$];

  mdc_dma_ctrl #(.MEM_AW(AW)) mdc_dma_ctrl_i (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .core_en(core_en),
    .core_we(core_we),
    .core_addr(core_addr),
    .core_wdata(core_wdata),
    .core_rdata(core_rdata),
    .cfg_we(cfg_we),
    .cfg_chan(cfg_chan),
    .cfg_int_addr(cfg_int_addr),
    .cfg_ext_addr(cfg_ext_addr),
    .cfg_count(cfg_count),
    .cfg_path(cfg_path),
    .cfg_to_int(cfg_to_int),
    .cfg_pack(cfg_pack),
    .chan_req(chan_req),
    .link_req(link_req),
    .share_link(share_link),
    .ext_xfer_request(ext_xfer_request),
    .ext_xfer_grant(ext_xfer_grant),
    .ext_req(ext_req),
    .ext_we(ext_we),
    .ext_addr(ext_addr),
    .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata),
    .ext_ack(ext_ack),
    .io_strobe(io_strobe),
    .io_chan(io_chan),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .chan_active(chan_active),
    .chan_pending(chan_pending),
    .link_owner(link_owner),
    .done_irq(done_irq)
  );
  mdc_far_model mdc_far_model_i (
    .clock(clock),
    .srst(srst),
    .wait_n(wait_n),
    .ext_req(ext_req),
    .ext_we(ext_we),
    .ext_addr(ext_addr),
    .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata),
    .ext_ack(ext_ack),
    .io_strobe(io_strobe),
    .io_chan(io_chan),
    .io_rdata(io_rdata)
  );

  always #20 clock = ~clock;

  // ********************
  // monitors and hang guard
  // ********************
  always @(posedge clock) begin
    cycles++;
    if (io_strobe === 1'b1) begin
      chq.push_back(io_chan);
      if (io_chan === 4'h2) begin
        wq.push_back(io_wdata);
      end
    end
    for (int c = 0; c < CH_NUM; c++) done_n[c] += int'(done_irq[c] === 1'b1);
    for (int p = 0; p < EXTREQ_NUM; p++) grants[p] += int'(ext_xfer_grant[p] === 1'b1);
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  // ********************
  // shared tasks
  // ********************
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check

  task automatic cfg(input int ch, ia, ea, n, input logic [1:0] p, input logic ti,
                     input logic [1:0] pk);
    cfg_we = 1'b1;
    cfg_chan = CH_W'(ch);
    cfg_int_addr = ADDR_W'(ia);
    cfg_ext_addr = ADDR_W'(ea);
    cfg_count = CNT_W'(n);
    cfg_path = p;
    cfg_to_int = ti;
    cfg_pack = pk;
    @(negedge clock);
    cfg_we = 1'b0;
    @(negedge clock);
  endtask : cfg

  task automatic core_wr(input int a, input logic [WORD_W-1:0] d);
    core_en = 1'b1;
    core_we = 1'b1;
    core_addr = AW'(a);
    core_wdata = d;
    @(negedge clock);
    core_en = 1'b0;
    core_we = 1'b0;
    @(negedge clock);
  endtask : core_wr

  // registered read: data shows the cycle after the request
  task automatic core_rd(input int a, output logic [WORD_W-1:0] d);
    core_en = 1'b1;
    core_addr = AW'(a);
    @(negedge clock);
    d = core_rdata;
    core_en = 1'b0;
    @(negedge clock);
  endtask : core_rd

  task automatic wait_done(input int ch);
    int k;
    k = 0;
    while (done_irq[ch] !== 1'b1 && k < 500) begin
      @(negedge clock);
      k++;
    end
    check(k < 500, "completion pulse missing");
    @(negedge clock);
  endtask : wait_done

  function automatic logic [15:0] beat(input int p, input int i);
    return 16'(16'h1111 * i + 16'h0100 * p + 16'h0005);
  endfunction : beat

  // ********************
  // scenarios
  // ********************
  task automatic t_idle();
    cfg(3, 0, 0, 0, PATH_IO, 1'b0, PACK_16);
    cfg(10, 0, 0, 1, PATH_IO, 1'b0, PACK_16);
    @(negedge clock);
    check(chan_active === '0 && chan_pending === '0, "bad descriptor taken");
    check(ext_req === 1'b0 && done_irq === '0, "activity at rest");
    share_link = 4'h1;
    repeat (2) @(negedge clock);
    check(link_owner === 4'h1, "link use of shared channel refused");
    // a port-side request must not run a channel that the link side owns
    cfg(4, 10, 0, 1, PATH_IO, 1'b1, PACK_16);
    chan_req[4] = 1'b1;
    share_link = 4'h0;
    repeat (8) @(negedge clock);
    check(chan_active[4] === 1'b1 && link_owner === 4'h1, "shared channel misused");
    link_req[0] = 1'b1;
    wait_done(4);
    link_req[0] = 1'b0;
    chan_req[4] = 1'b0;
    repeat (2) @(negedge clock);
    check(link_owner === 4'h0 && chan_active[4] === 1'b0, "owner not handed back");
  endtask : t_idle

  // internal word to the bus as two beats, core busy meanwhile
  task automatic t_to_ext();
    logic [WORD_W-1:0] d;
    core_wr(5, 48'hAAAA_BBBB_CCCC);
    cfg(6, 5, 'h40, 1, PATH_EXT, 1'b0, PACK_32);
    chan_req[6] = 1'b1;
    core_wr(9, 48'h1234_5678_9ABC);
    wait_done(6);
    chan_req[6] = 1'b0;
    check(mdc_far_model_i.mem[8'h40] === 16'hCCCC, "low beat wrong");
    check(mdc_far_model_i.mem[8'h41] === 16'hBBBB, "high beat wrong");
    check(mdc_far_model_i.mem[8'h42] === 16'h0000, "extra beat sent");
    check(chan_active[6] === 1'b0, "channel still active");
    core_rd(9, d);
    check(d === 48'h1234_5678_9ABC, "core write lost");
  endtask : t_to_ext

  // each pin request paces two packed words in from a slow bus
  task automatic t_pins();
    logic [WORD_W-1:0] d;
    int g;
    wait_n = 4'h3;
    for (int p = 0; p < EXTREQ_NUM; p++) begin
      for (int i = 0; i < 6; i++) mdc_far_model_i.mem[16 + 6 * p + i] = beat(p, i);
      cfg(8 + p, 20 + 2 * p, 16 + 6 * p, 2, PATH_EXT, 1'b1, PACK_48);
      g = grants[p];
      ext_xfer_request[p] = 1'b1;
      wait_done(8 + p);
      ext_xfer_request[p] = 1'b0;
      check(grants[p] - g == 2, "grant count wrong");
      core_rd(20 + 2 * p, d);
      check(d === {beat(p, 2), beat(p, 1), beat(p, 0)}, "first word wrong");
      core_rd(21 + 2 * p, d);
      check(d === {beat(p, 5), beat(p, 4), beat(p, 3)}, "second word wrong");
    end
    wait_n = 4'h0;
  endtask : t_pins

  // two port channels at once, the lower one with a queued follow-on
  task automatic t_chain();
    logic [WORD_W-1:0] d;
    int d2, d3, k;
    core_wr(1, 48'h0000_1111_2222);
    core_wr(3, 48'h3333_4444_5555);
    cfg(2, 1, 0, 1, PATH_IO, 1'b0, PACK_16);
    cfg(3, 2, 0, 1, PATH_IO, 1'b1, PACK_16);
    cfg(2, 3, 0, 1, PATH_IO, 1'b0, PACK_16);
    check(chan_pending[2] === 1'b1, "follow-on not queued");
    chq.delete();
    wq.delete();
    d2 = done_n[2];
    d3 = done_n[3];
    k = 0;
    chan_req[3:2] = 2'b11;
    while ((done_n[2] - d2 < 2 || done_n[3] - d3 < 1) && k < 300) begin
      @(negedge clock);
      k++;
    end
    chan_req[3:2] = 2'b00;
    check(k < 300, "chained run stalled");
    check(chq.size() == 3 && chq[0] === 4'h2, "priority order wrong");
    check(wq.size() == 2 && wq[0] === 48'h0000_1111_2222, "first port word");
    check(wq.size() == 2 && wq[1] === 48'h3333_4444_5555, "chained word");
    core_rd(2, d);
    check(d === {12'hC3C, 32'h0000_0000, 4'h3}, "port word not stored");
  endtask : t_chain

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (20) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    t_idle();
    t_to_ext();
    t_pins();
    t_chain();
    wrap_up();
  end
endmodule : tb
